// ==== cbr_pkg.sv ====
// Constants and types for the codec control register bank.
// Assumes a single 100 MHz clock; all serial timing is enable-pulse based.
package cbr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Control word layout
    localparam int          WORD_W      = 16;
    localparam int          DEV_HI      = 15;
    localparam int          DEV_LO      = 13;
    localparam int          RW_BIT      = 12;
    localparam int          RA_HI       = 11;
    localparam int          RA_LO       = 9;
    localparam int          DATA_HI     = 7;
    localparam logic [4:0]  LAST_BIT    = 5'h0F;

    // Register addresses (word bits 11..9)
    localparam logic [2:0]  REG_NOP     = 3'h0;
    localparam logic [2:0]  REG_CTRL1   = 3'h1;
    localparam logic [2:0]  REG_CTRL2   = 3'h2;
    localparam logic [2:0]  REG_CTRL3   = 3'h3;
    localparam logic [2:0]  REG_CTRL4   = 3'h4;

    // Field positions of control_one
    localparam int          C1_OVF      = 7;
    localparam int          C1_RX_AMP   = 6;
    localparam int          C1_AA_BYP   = 5;
    localparam int          C1_AUX_SEL  = 4;
    localparam int          C1_SW_RST   = 3;
    localparam int          C1_FIR_BYP  = 2;
    localparam int          C1_TX_AMP   = 1;
    localparam int          C1_DAC16    = 0;

    // Field positions of control_two and control_three
    localparam int          C2_LOW_PWR  = 7;
    localparam int          C2_MOD_STOP = 6;
    localparam int          C2_RSVD     = 5;
    localparam int          C2_DIV_HI   = 4;
    localparam int          C3_LOOP_HI  = 7;
    localparam int          C3_LOOP_LO  = 6;

    // Loopback codes
    localparam logic [1:0]  LOOP_NORMAL = 2'h0;
    localparam logic [1:0]  LOOP_ANALOG = 2'h1;
    localparam logic [1:0]  LOOP_DIGITAL = 2'h2;

    // Values after reset and divider constants
    localparam logic [7:0]  RST_CTRL    = 8'h00;
    localparam logic [2:0]  RST_ADDR    = 3'h0;
    localparam logic [5:0]  DIV_N_ZERO  = 6'h20;
    localparam logic [4:0]  RST_DIV_CNT = 5'h00;

    // Serial frame: one sync slot, 16 data slots, then idle slots
    localparam logic [4:0]  FRAME_SLOTS = 5'h14;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SYNC,
        PH_SHIFT
    } cbr_phase_e;

    typedef struct packed {
        cbr_phase_e         phase;
        logic [4:0]         slot;
        logic               fs;
        logic [WORD_W-1:0]  rx_sh;
        logic [WORD_W-1:0]  tx_sh;
        logic [WORD_W-1:0]  rd_word;
        logic               rd_pend;
        logic [7:0]         ctrl1;
        logic [7:0]         ctrl2;
        logic [7:0]         ctrl3;
        logic [7:0]         ctrl4;
        logic [2:0]         my_addr;
        logic               addr_cap;
        logic               soft_rst;
    } cbr_state_s;

    typedef struct packed {
        logic [4:0]         cnt;
        logic               sclk;
        logic               tick;
    } cbr_div_s;

    typedef struct packed {
        logic               receive_amp_en;
        logic               aa_filter_bypass;
        logic               aux_input_select;
        logic               fir_bypass;
        logic               transmit_amp_en;
        logic               dac_16bit;
        logic               low_power;
        logic               modulator_stop;
        logic [5:0]         div_n;
        logic [1:0]         loop_mode;
        logic [5:0]         ctrl3_low;
        logic [7:0]         gain;
    } cbr_cfg_s;

    localparam cbr_state_s ST_RESET = '{
        phase:    PH_IDLE,
        slot:     5'h00,
        fs:       1'b0,
        rx_sh:    16'h0000,
        tx_sh:    16'h0000,
        rd_word:  16'h0000,
        rd_pend:  1'b0,
        ctrl1:    RST_CTRL,
        ctrl2:    RST_CTRL,
        ctrl3:    RST_CTRL,
        ctrl4:    RST_CTRL,
        my_addr:  RST_ADDR,
        addr_cap: 1'b0,
        soft_rst: 1'b0
    };

endpackage : cbr_pkg

// ==== cbr_sclk_div.sv ====
// Serial clock divider: divides the master clock by N (1..32).
// Assumes the divider code may change at any time; the count wraps safely.
`timescale 1ns/100ps
module cbr_sclk_div (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [4:0] div_code,
    output logic            sclk,
    output logic            tick
);
    import cbr_pkg::*;

    cbr_div_s   st_q;
    cbr_div_s   st_d;
    logic [5:0] n_val;
    logic [5:0] half;
    logic [4:0] nm1;
    logic [4:0] cnt_n;

    ////////////////////////////////////////////////////////////////////////////
    // Code zero stands for 32
    assign n_val = (div_code == 5'h00) ? DIV_N_ZERO : {1'b0, div_code};
    assign half  = 6'((n_val + 6'h01) >> 1);
    assign nm1   = 5'(n_val - 6'h01);

    // Odd N gives an uneven high/low split; users only rely on tick
    always_comb begin
        st_d      = st_q;
        cnt_n     = (st_q.cnt >= nm1) ? 5'h00 : 5'(st_q.cnt + 5'h01);
        st_d.cnt  = cnt_n;
        st_d.tick = (st_q.cnt >= nm1);
        st_d.sclk = ({1'b0, cnt_n} < half);
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= '{cnt: RST_DIV_CNT, sclk: 1'b0, tick: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign sclk = st_q.sclk;
    assign tick = st_q.tick;

endmodule // cbr_sclk_div

// ==== cbr_bank.sv ====
// Codec control register bank, reached through 16-bit serial control words.
// Assumes din is synchronous to clock and the host times bits to sclk/fs.
// Summary of operation
// - Top three word bits address the device; stand-alone answers to 000.
// - Cascade position fixes the address; master highest, slaves below by position.
// - Word bits 11..9 pick register 1..4 or no-op; bit 8 ignored; low byte data.
// - Word bit 12 low writes the register, high reads it.
// - Control one bit 7 reports decimation filter overflow.
// - Control one bit 6 enables the receive amplifier.
// - Control one bit 4 picks auxiliary input pair, else main pair.
// - Control one bit 3 gives a one-shot soft reset and clears itself.
// - Control one bit 2 bypasses decimation and interpolation filters.
// - Control one bit 1 enables both transmit amplifiers.
// - Control one bit 0 selects full 16-bit playback words, else 15+control.
// - Control two low five bits set divider N; code zero means 32.
// - Uneven serial clock with odd N must not break transfers.
// - Even serial clock with even N must not break transfers.
`timescale 1ns/100ps
module cbr_bank (
    input  wire logic           clock,
    input  wire logic           rst,
    input  wire logic [2:0]     cascade_addr,
    input  wire logic           dec_overflow,
    input  wire logic           din,
    output logic                sclk,
    output logic                fs,
    output logic                dout,
    output logic                dout_en,
    output logic                soft_reset,
    output cbr_pkg::cbr_cfg_s   cfg
);
    import cbr_pkg::*;

    cbr_state_s         st_q;
    cbr_state_s         st_d;
    logic               tick;
    logic [WORD_W-1:0]  rx_next;
    logic               word_done;
    logic               hit;
    logic               wr_hit;
    logic               rd_hit;
    logic [2:0]         ra;
    logic [7:0]         wdat;
    logic [7:0]         regval;

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock generation
    cbr_sclk_div i_cbr_sclk_div (
        .clock    (clock),
        .rst      (rst),
        .div_code (st_q.ctrl2[C2_DIV_HI:0]),
        .sclk     (sclk),
        .tick     (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Word decode helpers
    assign rx_next = {st_q.rx_sh[WORD_W-2:0], din};
    assign ra      = rx_next[RA_HI:RA_LO];
    assign wdat    = rx_next[DATA_HI:0];
    assign hit     = word_done && (rx_next[DEV_HI:DEV_LO] == st_q.my_addr);
    assign wr_hit  = hit && !rx_next[RW_BIT];
    assign rd_hit  = hit && rx_next[RW_BIT];

    // Read-back mux; no-op and unused addresses read as zero
    always_comb begin
        case (ra)
            REG_CTRL1: regval = st_q.ctrl1;
            REG_CTRL2: regval = st_q.ctrl2;
            REG_CTRL3: regval = st_q.ctrl3;
            REG_CTRL4: regval = st_q.ctrl4;
            default:   regval = RST_CTRL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: frame sequencing, decode, flags
    always_comb begin
        st_d          = st_q;
        st_d.soft_rst = 1'b0;
        word_done     = 1'b0;
        // Address strap taken once after reset release, never under reset
        if (!st_q.addr_cap) begin
            st_d.my_addr  = cascade_addr;
            st_d.addr_cap = 1'b1;
        end
        // Every serial step waits for tick, so sclk duty never matters
        if (tick) begin
            case (st_q.phase)
                PH_SYNC: begin
                    st_d.fs      = 1'b0;
                    st_d.phase   = PH_SHIFT;
                    st_d.slot    = 5'h00;
                    st_d.tx_sh   = st_q.rd_pend ? st_q.rd_word : 16'h0000;
                    st_d.rd_pend = 1'b0;
                end
                PH_SHIFT: begin
                    st_d.rx_sh = rx_next;
                    st_d.tx_sh = {st_q.tx_sh[WORD_W-2:0], 1'b0};
                    st_d.slot  = 5'(st_q.slot + 5'h01);
                    if (st_q.slot == LAST_BIT) begin
                        word_done  = 1'b1;
                        st_d.phase = PH_IDLE;
                    end
                end
                PH_IDLE: begin
                    st_d.slot = 5'(st_q.slot + 5'h01);
                    if (5'(st_q.slot + 5'h01) >= 5'(FRAME_SLOTS - 5'h01)) begin
                        st_d.phase = PH_SYNC;
                        st_d.fs    = 1'b1;
                    end
                end
                default: begin
                    st_d.phase = PH_IDLE;
                    st_d.slot  = 5'h00;
                    st_d.fs    = 1'b0;
                end
            endcase
        end
        // Register writes; the written soft-reset bit is never stored
        if (wr_hit) begin
            case (ra)
                REG_CTRL1: begin
                    if (wdat[C1_SW_RST]) begin
                        st_d.ctrl1    = RST_CTRL;
                        st_d.ctrl2    = RST_CTRL;
                        st_d.ctrl3    = RST_CTRL;
                        st_d.ctrl4    = RST_CTRL;
                        st_d.soft_rst = 1'b1;
                    end else begin
                        st_d.ctrl1 = {st_q.ctrl1[C1_OVF], wdat[C1_RX_AMP:C1_AUX_SEL],
                                      1'b0, wdat[C1_FIR_BYP:C1_DAC16]};
                    end
                end
                REG_CTRL2: st_d.ctrl2 = {wdat[C2_LOW_PWR:C2_MOD_STOP], 1'b0,
                                         wdat[C2_DIV_HI:0]};
                REG_CTRL3: st_d.ctrl3 = wdat;
                REG_CTRL4: st_d.ctrl4 = wdat;
                default: begin
                    st_d.ctrl4 = st_q.ctrl4; // No operation
                end
            endcase
        end
        // Read: answer goes out in the following frame
        if (rd_hit && (ra != REG_NOP)) begin
            st_d.rd_word = {rx_next[DEV_HI:WORD_W-8], regval};
            st_d.rd_pend = 1'b1;
            if (ra == REG_CTRL1) begin
                st_d.ctrl1[C1_OVF] = 1'b0;
            end
        end
        // Overflow set wins over read-clear and soft reset
        if (dec_overflow) begin
            st_d.ctrl1[C1_OVF] = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from the state flops; dout_en and cfg.div_n pass through a decode
    assign fs                   = st_q.fs;
    assign dout                 = st_q.tx_sh[WORD_W-1];
    assign dout_en              = (st_q.phase == PH_SHIFT);
    assign soft_reset           = st_q.soft_rst;
    assign cfg.receive_amp_en   = st_q.ctrl1[C1_RX_AMP];
    assign cfg.aa_filter_bypass = st_q.ctrl1[C1_AA_BYP];
    assign cfg.aux_input_select = st_q.ctrl1[C1_AUX_SEL];
    assign cfg.fir_bypass       = st_q.ctrl1[C1_FIR_BYP];
    assign cfg.transmit_amp_en  = st_q.ctrl1[C1_TX_AMP];
    assign cfg.dac_16bit        = st_q.ctrl1[C1_DAC16];
    assign cfg.low_power        = st_q.ctrl2[C2_LOW_PWR];
    assign cfg.modulator_stop   = st_q.ctrl2[C2_MOD_STOP];
    // Code zero means the longest division
    assign cfg.div_n            = (st_q.ctrl2[C2_DIV_HI:0] == 5'h00) ? DIV_N_ZERO
                                  : {1'b0, st_q.ctrl2[C2_DIV_HI:0]};
    assign cfg.loop_mode        = st_q.ctrl3[C3_LOOP_HI:C3_LOOP_LO];
    assign cfg.ctrl3_low        = st_q.ctrl3[C3_LOOP_LO-1:0];
    assign cfg.gain             = st_q.ctrl4;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_write(logic [2:0] r);
        wr_hit && (ra == r);
    endsequence

    sequence s_read;
        rd_hit && (ra != REG_NOP);
    endsequence

    property p_addr_miss;
        @(posedge clock) disable iff (rst)
        (word_done && !hit) |=> $stable(st_q.ctrl2) && $stable(st_q.ctrl3)
                               && $stable(st_q.ctrl4);
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("foreign word changed a register");

    property p_strap_hold;
        @(posedge clock) disable iff (rst)
        st_q.addr_cap |=> $stable(st_q.my_addr) && st_q.addr_cap;
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("device address moved");

    property p_wr_ctrl3;
        logic [7:0] v;
        @(posedge clock) disable iff (rst)
        (s_write(REG_CTRL3), v = wdat) |=> (st_q.ctrl3 == v) && (cfg.loop_mode == v[7:6]);
    endproperty
    a_wr_ctrl3: assert property (p_wr_ctrl3) else $error("control three write lost");

    property p_read_keeps;
        @(posedge clock) disable iff (rst)
        rd_hit |=> $stable(st_q.ctrl2) && $stable(st_q.ctrl3) && $stable(st_q.ctrl4);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read altered a register");

    property p_read_data;
        logic [7:0] v;
        @(posedge clock) disable iff (rst)
        (s_read, v = regval) |=> st_q.rd_pend && (st_q.rd_word[7:0] == v);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read answer wrong");

    property p_ovf_set;
        @(posedge clock) disable iff (rst)
        dec_overflow |=> st_q.ctrl1[C1_OVF];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

    property p_soft_rst;
        @(posedge clock) disable iff (rst)
        s_write(REG_CTRL1) ##0 wdat[C1_SW_RST] |=> soft_reset && !st_q.ctrl1[C1_SW_RST]
            && (st_q.ctrl2 == RST_CTRL) ##1 !soft_reset;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset not one-shot");

    property p_div_map;
        @(posedge clock) disable iff (rst)
        (st_q.ctrl2[4:0] == 5'h00) |-> (cfg.div_n == 6'h20);
    endproperty
    a_div_map: assert property (p_div_map) else $error("divider code zero not 32");

    property p_tick_gap;
        @(posedge clock) disable iff (rst)
        (tick && !wr_hit && (cfg.div_n == 6'h03) && $stable(cfg.div_n)) |=> !tick ##1 !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("odd divider tick spacing wrong");

    property p_sync_shift;
        @(posedge clock) disable iff (rst)
        (tick && (st_q.phase == PH_SYNC)) |=> dout_en && !fs && (st_q.slot == 5'h00);
    endproperty
    a_sync_shift: assert property (p_sync_shift) else $error("frame did not start");

    property p_reserved;
        @(posedge clock) disable iff (rst)
        s_write(REG_CTRL2) |=> !st_q.ctrl2[C2_RSVD];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit stored");

    // Field paths: written control one bits 6, 4, 2, 1 and 0 must reach their cfg outputs
    sequence s_wr_c1;
        wr_hit && (ra == REG_CTRL1) && !wdat[C1_SW_RST];
    endsequence

    property p_rx_amp;
        @(posedge clock) disable iff (rst)
        s_wr_c1 |=> cfg.receive_amp_en == $past(wdat[C1_RX_AMP]);
    endproperty
    a_rx_amp: assert property (p_rx_amp) else $error("receive amp enable lost");

    property p_aux_sel;
        @(posedge clock) disable iff (rst)
        s_wr_c1 |=> cfg.aux_input_select == $past(wdat[C1_AUX_SEL]);
    endproperty
    a_aux_sel: assert property (p_aux_sel) else $error("input select lost");

    property p_fir_byp;
        @(posedge clock) disable iff (rst)
        s_wr_c1 |=> cfg.fir_bypass == $past(wdat[C1_FIR_BYP]);
    endproperty
    a_fir_byp: assert property (p_fir_byp) else $error("filter bypass lost");

    property p_tx_amp;
        @(posedge clock) disable iff (rst)
        s_wr_c1 |=> cfg.transmit_amp_en == $past(wdat[C1_TX_AMP]);
    endproperty
    a_tx_amp: assert property (p_tx_amp) else $error("transmit amp enable lost");

    property p_dac16;
        @(posedge clock) disable iff (rst)
        s_wr_c1 |=> cfg.dac_16bit == $past(wdat[C1_DAC16]);
    endproperty
    a_dac16: assert property (p_dac16) else $error("playback format lost");

    // Flag holds until a word decides; a read of control one clears it
    property p_ovf_keep;
        @(posedge clock) disable iff (rst)
        (st_q.ctrl1[C1_OVF] && !word_done) |=> st_q.ctrl1[C1_OVF];
    endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag dropped");

    property p_ovf_clear;
        @(posedge clock) disable iff (rst)
        (s_read ##0 ((ra == REG_CTRL1) && !dec_overflow)) |=> !st_q.ctrl1[C1_OVF];
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

    property p_div_track;
        @(posedge clock) disable iff (rst)
        (s_write(REG_CTRL2) ##0 (wdat[C2_DIV_HI:0] != 5'h00))
            |=> cfg.div_n == {1'b0, $past(wdat[C2_DIV_HI:0])};
    endproperty
    a_div_track: assert property (p_div_track) else $error("divider code not applied");

    property p_low_pwr;
        @(posedge clock) disable iff (rst)
        s_write(REG_CTRL2) |=> (cfg.low_power == $past(wdat[C2_LOW_PWR]))
            && (cfg.modulator_stop == $past(wdat[C2_MOD_STOP]));
    endproperty
    a_low_pwr: assert property (p_low_pwr) else $error("power or modulator bit lost");

    // Foreign words and no-op reads queue no answer
    property p_miss_read;
        @(posedge clock) disable iff (rst)
        (word_done && !hit && !st_q.rd_pend) |=> !st_q.rd_pend;
    endproperty
    a_miss_read: assert property (p_miss_read) else $error("foreign word answered");

    property p_nop_read;
        @(posedge clock) disable iff (rst)
        (rd_hit && (ra == REG_NOP) && !st_q.rd_pend) |=> !st_q.rd_pend;
    endproperty
    a_nop_read: assert property (p_nop_read) else $error("no-op read answered");

endmodule // cbr_bank

// ==== cbr_host_model.sv ====
// Host serial port model: sends one control word in every frame, MSB first.
// Assumes the host knows the divider N it programmed; din changes on falling edges.
`timescale 1ns/100ps
module cbr_host_model (
    input  wire logic        clock,
    input  wire logic        fs,
    input  wire logic        dout,
    input  wire logic [31:0] n,
    input  wire logic [15:0] word,
    output logic             din,
    output logic [15:0]      rx_word,
    output int               frames
);
    logic        fs_q  = 1'b0;
    logic [15:0] sh    = 16'h0000;
    logic [15:0] cap   = 16'h0000;
    int          bit_i = 16;
    int          cnt   = 0;

    initial begin
        din = 1'b0;
        rx_word = 16'h0000;
        frames = 0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One bit per N clocks from the fall of frame sync; answer captured half a clock into each slot
    always @(negedge clock) begin
        if (cnt > 0) cnt = cnt - 1;
        if (fs_q && !fs) begin
            sh = word;
            bit_i = 15;
            cnt = 0;
        end
        if (bit_i <= 15 && cnt == 0) begin
            if (bit_i < 0) begin
                rx_word = cap;
                frames = frames + 1;
                bit_i = 16;
            end else begin
                din = sh[bit_i];
                cap[bit_i] = dout;
                cnt = n;
                bit_i = bit_i - 1;
            end
        end else if (bit_i > 15) begin
            din = ~din; // Released line: no stale value to lean on
        end
        fs_q = fs;
    end
endmodule // cbr_host_model

// ==== cbr_bank_tb.sv ====
// Self-checking bench for the codec control register bank.
// Assumes cbr_host_model as the host; all inputs change on falling edges.
`timescale 1ns/100ps
module cbr_bank_tb;
    import cbr_pkg::*;
    typedef struct packed {
        logic [2:0] ra;
        logic [7:0] wd;
        logic [7:0] rb;
    } cbr_row_s;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  cascade_addr = 3'h0;
    logic        dec_overflow = 1'b0;
    logic        din, sclk, fs, dout, dout_en, soft_reset;
    cbr_cfg_s    cfg;
    int          n = 32;
    logic [15:0] word = 16'h0000;
    logic [15:0] rx_word;
    int          frames;
    logic [2:0]  dev = 3'h0;
    logic [7:0]  r [1:4] = '{default: 8'h00};
    int          mismatches = 0;
    int          tests_run = 0;
    int          sr_cnt = 0;
    int          s0;
    // Register, data written, value read back
    cbr_row_s    rows [8] = '{'{REG_CTRL1, 8'hF7, 8'h77}, '{REG_CTRL1, 8'h80, 8'h00},
                              '{REG_CTRL2, 8'hE3, 8'hC3}, '{REG_CTRL3, 8'h40, 8'h40},
                              '{REG_CTRL3, 8'h80, 8'h80}, '{REG_CTRL3, 8'hD5, 8'hD5},
                              '{REG_CTRL4, 8'hA5, 8'hA5}, '{REG_CTRL1, 8'h55, 8'h55}};

    initial begin
        forever #5 clock = ~clock;
    end

    cbr_bank i_cbr_bank (.clock(clock), .rst(rst), .cascade_addr(cascade_addr),
        .dec_overflow(dec_overflow), .din(din), .sclk(sclk), .fs(fs), .dout(dout),
        .dout_en(dout_en), .soft_reset(soft_reset), .cfg(cfg));
    cbr_host_model i_cbr_host_model (.clock(clock), .fs(fs), .dout(dout), .n(n),
        .word(word), .din(din), .rx_word(rx_word), .frames(frames));

    // Soft reset pulses, counted so a stretched pulse shows up
    always @(posedge clock) if (soft_reset === 1'b1) sr_cnt <= sr_cnt + 1;

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One frame carrying w; idles the host with a no-op afterwards
    task automatic frame(input logic [15:0] w);
        int f0;
        int i;
        f0 = frames;
        word = w;
        for (i = 0; i < 2000 && frames == f0; i++) @(negedge clock);
        word = {dev, 1'b0, REG_NOP, 9'h000};
        if (frames == f0) begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic wr(input logic [2:0] ra, input logic [7:0] d);
        frame({dev, 1'b0, ra, 1'b0, d});
    endtask

    // Answer arrives in the frame after the read
    task automatic rd_chk(input logic [2:0] ra, input logic [7:0] e);
        frame({dev, 1'b1, ra, 9'h000});
        frame({dev, 1'b0, REG_NOP, 9'h000});
        check("readback", rx_word, {dev, 1'b1, ra, 1'b0, e});
    endtask

    function automatic cbr_cfg_s exp_cfg();
        cbr_cfg_s c;
        c = '0;
        c.receive_amp_en = r[1][C1_RX_AMP];
        c.aa_filter_bypass = r[1][C1_AA_BYP];
        c.aux_input_select = r[1][C1_AUX_SEL];
        c.fir_bypass = r[1][C1_FIR_BYP];
        c.transmit_amp_en = r[1][C1_TX_AMP];
        c.dac_16bit = r[1][C1_DAC16];
        c.low_power = r[2][C2_LOW_PWR];
        c.modulator_stop = r[2][C2_MOD_STOP];
        c.div_n = (r[2][4:0] == 5'h00) ? DIV_N_ZERO : {1'b0, r[2][4:0]};
        c.loop_mode = r[3][7:6];
        c.ctrl3_low = r[3][5:0];
        c.gain = r[4];
        return c;
    endfunction

    // Counts falling edges until fs shows v, and sclk highs on the way
    task automatic wait_fs(input logic v, output int p, output int hi);
        hi = 0;
        for (p = 0; p < 2000 && fs !== v; p++) begin
            @(negedge clock);
            hi += (sclk === 1'b1) ? 1 : 0;
        end
        if (p == 2000) begin
            mismatches++;
            conclude();
        end
    endtask

    // Sets divider, then measures frame sync low and high spans
    task automatic div(input logic [4:0] code);
        int p;
        int hi;
        wr(REG_CTRL2, {r[2][7:5], code});
        r[2][4:0] = code;
        n = (code == 5'h00) ? 32 : int'(code);
        check("dout_en idle", dout_en, 1'b0);
        wait_fs(1'b1, p, hi);
        wait_fs(1'b0, p, hi);
        check("dout_en shift", dout_en, 1'b1);
        wait_fs(1'b1, p, hi);
        check("fs low span", p, 19 * n);
        wait_fs(1'b0, p, hi);
        check("fs high span", p, n);
        check("sclk high count", hi, (n + 1) / 2);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge clock);
        rst = 1'b0;
        check("cfg after reset", cfg, exp_cfg());
        rd_chk(REG_CTRL1, 8'h00);
        div(5'h01);
        div(5'h04);
        div(5'h00);
        div(5'h03);
        // Table of ordinary writes at odd N
        foreach (rows[i]) begin
            wr(rows[i].ra, rows[i].wd);
            r[rows[i].ra] = rows[i].rb;
            check("cfg", cfg, exp_cfg());
            rd_chk(rows[i].ra, rows[i].rb);
        end
        // Words for another device, no-op and unmapped registers change nothing
        frame({3'h1, 1'b0, REG_CTRL4, 9'h000});
        frame({dev, 1'b0, REG_NOP, 9'h0FF});
        frame({dev, 1'b0, 3'h5, 9'h0FF});
        check("cfg ignored", cfg, exp_cfg());
        frame({3'h1, 1'b1, REG_CTRL4, 9'h000});
        frame({dev, 1'b0, REG_NOP, 9'h000});
        check("no answer dev", rx_word, 16'h0000);
        frame({dev, 1'b1, 3'h7, 9'h000});
        frame({dev, 1'b0, REG_NOP, 9'h000});
        check("unmapped read", rx_word, {dev, 1'b1, 3'h7, 9'h000});
        frame({dev, 1'b1, REG_NOP, 9'h000});
        frame({dev, 1'b0, REG_NOP, 9'h000});
        check("no answer nop", rx_word, 16'h0000);
        frame({dev, 1'b0, REG_CTRL4, 1'b1, 8'h3C});
        r[4] = 8'h3C;
        check("bit 8 ignored", cfg, exp_cfg());
        // Overflow flag shows once, then read clears it
        dec_overflow = 1'b1;
        @(negedge clock);
        dec_overflow = 1'b0;
        rd_chk(REG_CTRL1, r[1] | 8'h80);
        rd_chk(REG_CTRL1, r[1]);
        // N of one with filters bypassed still transfers
        div(5'h01);
        wr(REG_CTRL4, 8'h81);
        r[4] = 8'h81;
        rd_chk(REG_CTRL4, 8'h81);
        // Soft reset: one pulse, all registers cleared, bit not kept
        s0 = sr_cnt;
        wr(REG_CTRL1, 8'h08);
        n = 32;
        r = '{default: 8'h00};
        repeat (2) @(negedge clock);
        check("soft reset pulses", sr_cnt - s0, 1);
        check("cfg soft reset", cfg, exp_cfg());
        rd_chk(REG_CTRL1, 8'h00);
        // Second reset as cascade master at 011
        rst = 1'b1;
        cascade_addr = 3'h3;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        dev = 3'h3;
        frame({3'h0, 1'b0, REG_CTRL4, 9'h0FF});
        check("cfg other addr", cfg, exp_cfg());
        wr(REG_CTRL4, 8'h5A);
        r[4] = 8'h5A;
        check("cfg master addr", cfg, exp_cfg());
        rd_chk(REG_CTRL4, 8'h5A);
        conclude();
    end
endmodule // cbr_bank_tb
